// >>> hdl/nibble_add_pkg.sv
// constants and types for the nibble add execution slice
package nibble_add_pkg;
  localparam int          word_w          = 10;
  localparam int          nib_w           = 4;
  localparam int          addr_w          = 6;
  localparam logic [5:0]  add_imm_op      = 6'h06;
  localparam logic [9:0]  add_mem_code    = 10'h00a;
  localparam logic [9:0]  add_mem_cy_code = 10'h00b;
  localparam logic [3:0]  acc_reset       = 4'h0;
  localparam logic        carry_reset     = 1'b0;
  localparam int          op_lsb          = 4;
  localparam logic [5:0]  addr_reset      = 6'h00;
  localparam logic        skip_reset      = 1'b0;
  localparam logic        done_reset      = 1'b0;
  typedef enum logic [1:0] {op_none, op_add_imm, op_add_mem, op_add_mem_cy} add_op_t;
endpackage : nibble_add_pkg

// >>> hdl/nibble_add_if.sv
// operand and result bundle between decoder and adder
`timescale 1ns/1ps
`default_nettype none
interface nibble_add_if;
  logic [3:0] lhs;
  logic [3:0] rhs;
  logic       cin;
  logic [3:0] sum;
  logic       cout;
  modport user (output lhs, output rhs, output cin, input sum, input cout);
  modport adder (input lhs, input rhs, input cin, output sum, output cout);
endinterface : nibble_add_if
`default_nettype wire

// >>> hdl/nibble_adder.sv
// 4-bit adder with carry in and carry out
`timescale 1ns/1ps
`default_nettype none
module nibble_adder
(
  nibble_add_if.adder bus
);
  import nibble_add_pkg::*;
  logic [4:0] total;
  always_comb
  begin
    total    = {1'b0, bus.lhs} + {1'b0, bus.rhs} + {4'h0, bus.cin};
    bus.sum  = total[3:0];
    bus.cout = total[4];
  end
endmodule : nibble_adder
`default_nettype wire

// >>> hdl/nibble_add_core.sv
// add instruction execution slice: accumulator, carry flag, skip
`timescale 1ns/1ps
`default_nettype none
module nibble_add_core
(
  input  wire logic                                 clock,
  input  wire logic                                 rst,
  input  wire logic                                 instr_valid,
  input  wire logic [nibble_add_pkg::word_w-1:0]    instr_word,
  input  wire logic [nibble_add_pkg::nib_w-1:0]     mem_nibble,
  input  wire logic [nibble_add_pkg::addr_w-1:0]    data_pointer,
  output logic      [nibble_add_pkg::addr_w-1:0]    mem_addr,
  output logic      [nibble_add_pkg::nib_w-1:0]     accumulator,
  output logic                                      carry_flag,
  output logic                                      skip_next,
  output logic                                      done
);
  import nibble_add_pkg::*;

  // decoded operation and adder operands
  add_op_t             op;
  logic [nib_w-1:0]    operand_b;
  logic                carry_in;

  // accumulator group
  logic [nib_w-1:0]    acc_q;
  logic [nib_w-1:0]    acc_d;

  // carry flag group
  logic                cy_q;
  logic                cy_d;

  // skip request group
  logic                skip_q;
  logic                skip_d;

  // completion pulse group
  logic                done_q;
  logic                done_d;

  // memory address group
  logic [addr_w-1:0]   addr_q;
  logic [addr_w-1:0]   addr_d;

  nibble_add_if sum_bus ();

  nibble_adder u_adder
  (
    .bus (sum_bus)
  );

  // immediate field of a word
  function automatic logic [nib_w-1:0] imm_field(input logic [word_w-1:0] w);
    return w[nib_w-1:0];
  endfunction : imm_field

  // opcode field of a word
  function automatic logic [word_w-op_lsb-1:0] op_field(input logic [word_w-1:0] w);
    return w[word_w-1:op_lsb];
  endfunction : op_field

  function automatic add_op_t decode(input logic [word_w-1:0] w);
    add_op_t kind;
    kind = op_none;
    if (op_field(w) == add_imm_op)
      kind = op_add_imm;
    else if (w == add_mem_code)
      kind = op_add_mem;
    else if (w == add_mem_cy_code)
      kind = op_add_mem_cy;
    return kind;
  endfunction : decode

  // operand selection for the shared adder
  always_comb
  begin
    op        = instr_valid ? decode(instr_word) : op_none;
    operand_b = mem_nibble;
    carry_in  = 1'b0;
    case (op)
      op_add_imm:
      begin
        operand_b = imm_field(instr_word);
      end
      op_add_mem_cy:
      begin
        carry_in = cy_q;
      end
      default:
      begin
        operand_b = mem_nibble;
      end
    endcase
    sum_bus.lhs = acc_q;
    sum_bus.rhs = operand_b;
    sum_bus.cin = carry_in;
  end

  // accumulator next value
  always_comb
  begin
    acc_d = acc_q;
    case (op)
      op_add_imm:
      begin
        acc_d = sum_bus.sum;
      end
      op_add_mem:
      begin
        acc_d = sum_bus.sum;
      end
      op_add_mem_cy:
      begin
        acc_d = sum_bus.sum;
      end
      default:
      begin
        acc_d = acc_q;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      acc_q <= acc_reset;
    end
    else
    begin
      acc_q <= acc_d;
    end
  end

  // carry flag next value
  always_comb
  begin
    cy_d = cy_q;
    case (op)
      op_add_imm:
      begin
        cy_d = cy_q;
      end
      op_add_mem_cy:
      begin
        cy_d = sum_bus.cout;
      end
      default:
      begin
        cy_d = cy_q;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cy_q <= carry_reset;
    end
    else
    begin
      cy_q <= cy_d;
    end
  end

  // skip request next value
  always_comb
  begin
    skip_d = 1'b0;
    case (op)
      op_add_imm:
      begin
        skip_d = ~sum_bus.cout;
      end
      default:
      begin
        skip_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      skip_q <= skip_reset;
    end
    else
    begin
      skip_q <= skip_d;
    end
  end

  // completion pulse next value
  always_comb
  begin
    done_d = 1'b0;
    case (op)
      op_add_imm,
      op_add_mem,
      op_add_mem_cy:
      begin
        done_d = 1'b1;
      end
      default:
      begin
        done_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      done_q <= done_reset;
    end
    else
    begin
      done_q <= done_d;
    end
  end

  // memory address follows the data pointer
  always_comb
  begin
    addr_d = data_pointer;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      addr_q <= addr_reset;
    end
    else
    begin
      addr_q <= addr_d;
    end
  end

  // outputs straight from the registers
  assign accumulator = acc_q;
  assign carry_flag  = cy_q;
  assign skip_next   = skip_q;
  assign done        = done_q;
  assign mem_addr    = addr_q;
endmodule : nibble_add_core
`default_nettype wire

// >>> test/nibble_add_mem_model.sv
// data memory model
`timescale 1ns/1ps
`default_nettype none
module nibble_add_mem_model
(
  input  wire logic [5:0] addr,
  output logic      [3:0] nibble
);
  assign nibble = addr[3:0] ^ 4'h5;
endmodule : nibble_add_mem_model
`default_nettype wire

// >>> test/nibble_add_core_assertions.sv
// add slice checks
`timescale 1ns/1ps
`default_nettype none
module nibble_add_core_assertions
(
  input wire logic                                 clock,
  input wire logic                                 rst,
  input wire logic                                 instr_valid,
  input wire logic                                 carry_flag,
  input wire logic                                 skip_next,
  input wire logic                                 done,
  input wire logic [nibble_add_pkg::word_w-1:0]    instr_word,
  input wire logic [nibble_add_pkg::nib_w-1:0]     mem_nibble,
  input wire logic [nibble_add_pkg::nib_w-1:0]     accumulator
);
  import nibble_add_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic imm;
  logic am;
  logic add_memory_with_carry;
  assign imm = instr_valid && instr_word[word_w-1:op_lsb] == add_imm_op;
  assign am  = instr_valid && instr_word == add_mem_code;
  assign add_memory_with_carry = instr_valid && instr_word == add_mem_cy_code;
  a_imm_sum: assert property (imm |=> accumulator == $past(accumulator) + $past(instr_word[nib_w-1:0]))
    else $error("imm sum");
  a_imm_carry: assert property (imm |=> $stable(carry_flag))
    else $error("imm carry");
  a_imm_skip: assert property (imm |=> skip_next == ($past(accumulator) + $past(instr_word[nib_w-1:0]) < 5'h10))
    else $error("skip");
  a_mem_sum: assert property (am |=> accumulator == $past(accumulator) + $past(mem_nibble))
    else $error("mem sum");
  a_mem_carry: assert property (am |=> $stable(carry_flag))
    else $error("mem carry");
  a_carry_sum: assert property (add_memory_with_carry |=> {carry_flag, accumulator} == $past(accumulator) + $past(mem_nibble) + $past(carry_flag))
    else $error("carry sum");
  a_one_cycle: assert property (imm || am || add_memory_with_carry |=> done)
    else $error("done");
  a_idle_quiet: assert property (!(imm || am || add_memory_with_carry) |=> !done && !skip_next)
    else $error("idle pulse");
endmodule : nibble_add_core_assertions
bind nibble_add_core nibble_add_core_assertions i_chk (.clock(clock), .rst(rst), .instr_valid(instr_valid),
  .carry_flag(carry_flag), .skip_next(skip_next), .done(done), .instr_word(instr_word),
  .mem_nibble(mem_nibble), .accumulator(accumulator));
`default_nettype wire

// >>> test/nibble_add_core_test.sv
// self-checking bench for the add slice
`timescale 1ns/1ps
`default_nettype none
module nibble_add_core_test;
  logic clock = 0, rst = 1, instr_valid = 0, carry_flag, skip_next, done;
  logic [9:0] instr_word = 10'h000;
  logic [5:0] data_pointer = 6'h0d;
  logic [3:0] mem_nibble, accumulator;
  logic [5:0] mem_addr;
  int num_errors = 0, n_checks = 0, cyc = 0;
  nibble_add_mem_model i_mem (.addr(data_pointer), .nibble(mem_nibble));
  nibble_add_core i_dut (.clock(clock), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
    .mem_nibble(mem_nibble), .data_pointer(data_pointer), .mem_addr(mem_addr), .accumulator(accumulator),
    .carry_flag(carry_flag), .skip_next(skip_next), .done(done));
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) if (++cyc == 200) begin num_errors++; test_done(); end
  task chk(input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin num_errors++; $display("[FAIL] %0t got %h want %h", $time, seen, exp); end
  endtask : chk
  // one instruction, then {done, skip, carry, acc}
  task run(input logic [9:0] w, input logic [7:0] exp);
    @(posedge clock);
    #1 instr_valid = 1;
    instr_word = w;
    @(posedge clock);
    #1 instr_valid = 0;
    chk({1'b0, done, skip_next, carry_flag, accumulator}, exp);
  endtask : run
  task t_imm();
    run(10'h06f, 8'h6f);
    run(10'h061, 8'h40);
  endtask : t_imm
  task t_mem();
    run(10'h069, 8'h69);
    run(10'h00b, 8'h51);
    run(10'h00b, 8'h4a);
    run(10'h00a, 8'h42);
    run(10'h000, 8'h02);
  endtask : t_mem
  // new pointer, carry held through an immediate overflow
  task t_ptr();
    data_pointer = 6'h2a;
    run(10'h00a, 8'h41);
    run(10'h00b, 8'h50);
    run(10'h068, 8'h78);
    run(10'h068, 8'h50);
    chk({2'b00, mem_addr}, 8'h2a);
  endtask : t_ptr
  // reset in mid-run, then a fresh instruction
  task t_reset();
    run(10'h06f, 8'h7f);
    rst = 1;
    @(posedge clock);
    #1 rst = 0;
    chk({1'b0, done, skip_next, carry_flag, accumulator}, 8'h00);
    chk({2'b00, mem_addr}, 8'h00);
    run(10'h061, 8'h61);
  endtask : t_reset
  task test_done();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (6) @(posedge clock);
    #1 rst = 0;
    t_imm();
    t_mem();
    t_ptr();
    t_reset();
    test_done();
  end
endmodule : nibble_add_core_test
`default_nettype wire
